// >>> pkg/iopg_pkg.sv
/*
  Register map, field layout and reset values of the I/O pin group.
  Assumes an 8-bit register port with byte offsets as printed.
*/
package iopg_pkg;
  localparam int IOPG_PINS = 8;
  localparam logic [5:0] IOPG_DIR = 6'h00;
  localparam logic [5:0] IOPG_DRIVE_ENABLE_SET = 6'h01;
  localparam logic [5:0] IOPG_DRIVE_ENABLE_CLEAR = 6'h02;
  localparam logic [5:0] IOPG_DRIVE_ENABLE_TOGGLE = 6'h03;
  localparam logic [5:0] IOPG_OUT = 6'h04;
  localparam logic [5:0] IOPG_DRIVE_VALUE_SET = 6'h05;
  localparam logic [5:0] IOPG_DRIVE_VALUE_CLEAR = 6'h06;
  localparam logic [5:0] IOPG_DRIVE_VALUE_TOGGLE = 6'h07;
  localparam logic [5:0] IOPG_IN = 6'h08;
  localparam logic [5:0] IOPG_FLAGS = 6'h09;
  localparam logic [5:0] IOPG_GCTRL = 6'h0A;
  localparam logic [5:0] IOPG_STAGE = 6'h0B;
  localparam logic [5:0] IOPG_COPY = 6'h0C;
  localparam logic [5:0] IOPG_ORSET = 6'h0D;
  localparam logic [5:0] IOPG_ANDCLR = 6'h0E;
  localparam logic [5:0] IOPG_PINCFG = 6'h10;
  // Fast alias window: drive_enable, drive_value, sampled_level, flags
  localparam logic [5:0] IOPG_ALIAS = 6'h20;
  localparam int IOPG_FLIP_BIT = 7;
  localparam int IOPG_PULL_BIT = 3;
  localparam logic [7:0] IOPG_CFG_MASK = 8'h8F;
  localparam logic [2:0] IOPG_SENSE_OFF = 3'h4;
  localparam logic [2:0] IOPG_SENSE_INTDIS = 3'h0;
  localparam logic [7:0] IOPG_RST8 = 8'h00;
  localparam logic [1:0] IOPG_DEAD_CYC = 2'h3;
  typedef logic [7:0] iopg_byte_t;
endpackage

// >>> pkg/iopg_pin_if.sv
/*
  Interface carrying the per-pin configuration from the main block to
  the pin sensing module. Assumes one clock for both ends.
*/
`timescale 1ns/1ps
interface iopg_pin_if;
  logic [7:0] sense_on;   // Input buffer enabled per pin
  logic [7:0] level;      // Polarity-corrected synchronized level
  logic [7:0] level_raw;  // Same with buffer gate, for events
  modport ctl (output sense_on, input level, input level_raw);
  modport snc (input sense_on, output level, output level_raw);
endinterface

// >>> hw/iopg_sync.sv
/*
  Two-stage synchroniser for the pin levels with per-pin hold while the
  input buffer is off. Assumes pin levels already corrected for polarity.
*/
`timescale 1ns/1ps
module iopg_sync
  import iopg_pkg::*;
(
  input wire logic ref_clk,     // Peripheral clock
  input wire logic rst_n,       // Synchronous reset, active low
  input wire logic [7:0] pin_v, // Pin levels after polarity flip
  iopg_pin_if.snc pif           // Sense control and sampled level
);
  logic [7:0] s1_q;
  logic [7:0] s2_q;

  // First stage, read only by the second stage; held while buffer is off
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_q <= IOPG_RST8;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (pif.sense_on[i]) begin
          s1_q[i] <= pin_v[i];
        end
      end
    end
  end

  // Second stage holds its value while the synchroniser is disabled
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s2_q <= IOPG_RST8;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (pif.sense_on[i]) begin
          s2_q[i] <= s1_q[i];
        end
      end
    end
  end

  assign pif.level = s2_q;
  assign pif.level_raw = s2_q & pif.sense_on;
endmodule

// >>> hw/iopg_top.sv
/*
  One group of eight general purpose I/O pins: direction, drive value,
  sampled level, per-pin configuration with staged multi-pin update,
  slew limit, fast alias window, peripheral override, pin flags.
  Assumes an 8-bit register port with one-cycle strobes and read data
  in the following cycle; pin inputs synchronous to ref_clk.
*/
// Summary of operation
// - After reset all drivers are off and every input buffer is on.
// - A pin drives while its drive-enable bit is one.
// - Drive-enable set and clear strobes change only the written pins.
// - Drive-enable toggle strobe inverts the written bits.
// - Drive-value set strobe forces written bits to one.
// - Drive-value clear strobe forces written bits to zero.
// - Toggle strobe or a write to sampled level inverts drive bits.
// - Pin levels are synchronised and readable in either direction.
// - Slew-limit bit one limits slew on every pin of the group.
// - Pin n configuration sits at group base plus 0x10 plus n.
// - Polarity flip inverts input and output of that pin.
// - Changing the polarity flip makes an edge on the internal signal.
// - Pull-up connects only when enabled and the pin is an input.
// - Buffer-off setting stops the synchroniser; sampled bit holds.
// - Copy strobe loads the staged setting into selected pins.
// - Or strobe sets selected pins' bits that are one in the stage.
// - And-not strobe clears selected pins' bits one in the stage.
// - Staged setting is shared by all groups; strobes act locally.
// - Alias window accesses act exactly like the regular registers.
// - Peripheral override replaces only the aspects it claims.
// - Group request stays asserted while any pin flag is set.
// - Event output follows the level, zero with the buffer off.
// - No new pin interrupt for three clocks after the previous one.
`timescale 1ns/1ps
module iopg_top
  import iopg_pkg::*;
(
  input wire logic ref_clk,           // Peripheral clock, 200 MHz
  input wire logic rst_n,             // Synchronous reset, active low
  input wire logic [5:0] reg_addr,    // Register byte offset
  input wire logic [7:0] reg_wdata,   // Write data
  input wire logic reg_wr,            // Write strobe
  input wire logic reg_rd,            // Read strobe
  output logic [7:0] reg_rdata,       // Read data, cycle after strobe
  input wire logic [7:0] stage_in,    // Shared staged setting value
  output logic [7:0] stage_wr_data,   // Data for shared staged setting
  output logic stage_wr,              // Pulse: write shared stage
  input wire logic [7:0] pad_in,      // Pin levels
  output logic [7:0] pad_out,         // Pin drive levels
  output logic [7:0] pad_oe,          // Pin drive enables
  output logic [7:0] pad_pull,        // Weak pull-up enables
  output logic [7:0] pad_ibuf_en,     // Digital input buffer enables
  output logic pad_slew_limit,        // Slew limit for the group
  input wire logic [7:0] per_oe_ovr,  // Peripheral claims direction
  input wire logic [7:0] per_oe,      // Peripheral direction
  input wire logic [7:0] per_out_ovr, // Peripheral claims value
  input wire logic [7:0] per_out,     // Peripheral value
  output logic [7:0] pin_level,       // Level seen by peripherals
  output logic [7:0] pin_event,       // Event outputs
  output logic pin_irq                // Group interrupt request
);
  iopg_pin_if pif ();

  logic [7:0] dir_q;
  logic [7:0] out_q;
  logic [7:0] flag_q;
  logic slr_q;
  logic [7:0] cfg_q [IOPG_PINS];
  logic [7:0] flip;
  logic [7:0] lvl_prev_q;
  logic [1:0] dead_q [IOPG_PINS];
  logic [7:0] rdata_d;
  logic [5:0] ea;
  logic wr;

  // Alias window folds onto the regular offsets, so both paths share logic
  function automatic logic [5:0] alias_map(input logic [5:0] a);
    logic [5:0] r;
    r = a;
    if (a == IOPG_ALIAS) r = IOPG_DIR;
    else if (a == IOPG_ALIAS + 6'h01) r = IOPG_OUT;
    else if (a == IOPG_ALIAS + 6'h02) r = IOPG_IN;
    else if (a == IOPG_ALIAS + 6'h03) r = IOPG_FLAGS;
    return r;
  endfunction

  // Sense setting decides whether an edge, or for setting 5 a low level, sets the flag
  function automatic logic sense_hit(input logic [2:0] s, input logic p,
                                     input logic c);
    logic h;
    h = 1'b0;
    case (s)
      3'h1: h = p ^ c;
      3'h2: h = c & ~p;
      3'h3: h = p & ~c;
      3'h5: h = ~c;
      default: h = 1'b0;
    endcase
    return h;
  endfunction

  assign ea = alias_map(reg_addr);
  assign wr = reg_wr;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      flip[i] = cfg_q[i][IOPG_FLIP_BIT];
      pif.sense_on[i] = (cfg_q[i][2:0] != IOPG_SENSE_OFF);
    end
  end

  iopg_sync u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_v(pad_in ^ flip),
    .pif(pif)
  );

  // Direction register with hardware set, clear and toggle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dir_q <= IOPG_RST8;
    end else if (wr) begin
      case (ea)
        IOPG_DIR: dir_q <= reg_wdata;
        IOPG_DRIVE_ENABLE_SET: dir_q <= dir_q | reg_wdata;
        IOPG_DRIVE_ENABLE_CLEAR: dir_q <= dir_q & ~reg_wdata;
        IOPG_DRIVE_ENABLE_TOGGLE: dir_q <= dir_q ^ reg_wdata;
        default: dir_q <= dir_q;
      endcase
    end
  end

  // Drive value; stored as software writes it on every pin, flipped pins
  // get the complement only at the pad output
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      out_q <= IOPG_RST8;
    end else if (wr) begin
      case (ea)
        IOPG_OUT: out_q <= reg_wdata;
        IOPG_DRIVE_VALUE_SET: out_q <= out_q | reg_wdata;
        IOPG_DRIVE_VALUE_CLEAR: out_q <= out_q & ~reg_wdata;
        IOPG_DRIVE_VALUE_TOGGLE: out_q <= out_q ^ reg_wdata;
        IOPG_IN: out_q <= out_q ^ reg_wdata;
        default: out_q <= out_q;
      endcase
    end
  end

  // Slew limit control
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      slr_q <= 1'b0;
    end else if (wr && ea == IOPG_GCTRL) begin
      slr_q <= reg_wdata[0];
    end
  end

  // Staged setting lives outside: one storage for every group
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stage_wr <= 1'b0;
      stage_wr_data <= IOPG_RST8;
    end else begin
      stage_wr <= wr && ea == IOPG_STAGE;
      stage_wr_data <= reg_wdata & IOPG_CFG_MASK;
    end
  end

  // Per-pin configuration: direct write, copy, or and and-not strobes
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) cfg_q[i] <= IOPG_RST8;
    end else if (wr) begin
      for (int i = 0; i < 8; i++) begin
        if (ea == IOPG_PINCFG + 6'(i)) begin
          cfg_q[i] <= reg_wdata & IOPG_CFG_MASK;
        end else if (ea == IOPG_COPY && reg_wdata[i]) begin
          cfg_q[i] <= stage_in & IOPG_CFG_MASK;
        end else if (ea == IOPG_ORSET && reg_wdata[i]) begin
          cfg_q[i] <= cfg_q[i] | (stage_in & IOPG_CFG_MASK);
        end else if (ea == IOPG_ANDCLR && reg_wdata[i]) begin
          cfg_q[i] <= cfg_q[i] & ~stage_in;
        end
      end
    end
  end

  // Pin flags with dead time; a new event wins over a clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lvl_prev_q <= IOPG_RST8;
      flag_q <= IOPG_RST8;
      for (int i = 0; i < 8; i++) dead_q[i] <= 2'h0;
    end else begin
      lvl_prev_q <= pif.level;
      for (int i = 0; i < 8; i++) begin
        if (pif.sense_on[i] && dead_q[i] == 2'h0 &&
            sense_hit(cfg_q[i][2:0], lvl_prev_q[i], pif.level[i])) begin
          flag_q[i] <= 1'b1;
          dead_q[i] <= IOPG_DEAD_CYC;
        end else begin
          if (wr && ea == IOPG_FLAGS && reg_wdata[i]) flag_q[i] <= 1'b0;
          if (dead_q[i] != 2'h0) dead_q[i] <= dead_q[i] - 2'h1;
        end
      end
    end
  end

  // Pin drivers, overrides and status outputs, all registered
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pad_oe <= IOPG_RST8;
      pad_out <= IOPG_RST8;
      pad_pull <= IOPG_RST8;
      pad_ibuf_en <= 8'hFF;
      pad_slew_limit <= 1'b0;
      pin_level <= IOPG_RST8;
      pin_event <= IOPG_RST8;
      pin_irq <= 1'b0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        // Unclaimed aspects stay with the general purpose registers
        pad_oe[i] <= per_oe_ovr[i] ? per_oe[i] : dir_q[i];
        pad_out[i] <= (per_out_ovr[i] ? per_out[i] : out_q[i]) ^ flip[i];
        pad_pull[i] <= cfg_q[i][IOPG_PULL_BIT] &
                       ~(per_oe_ovr[i] ? per_oe[i] : dir_q[i]);
        pad_ibuf_en[i] <= pif.sense_on[i];
      end
      pad_slew_limit <= slr_q;
      pin_level <= pif.level;
      pin_event <= pif.level_raw;
      pin_irq <= |flag_q;
    end
  end

  // Read path; unmapped offsets read zero
  always_comb begin
    rdata_d = IOPG_RST8;
    case (ea)
      IOPG_DIR: rdata_d = dir_q;
      IOPG_OUT: rdata_d = out_q;
      IOPG_IN: rdata_d = pif.level;
      IOPG_FLAGS: rdata_d = flag_q;
      IOPG_GCTRL: rdata_d = {7'h00, slr_q};
      IOPG_STAGE: rdata_d = stage_in & IOPG_CFG_MASK;
      default: begin
        for (int i = 0; i < 8; i++) begin
          if (ea == IOPG_PINCFG + 6'(i)) rdata_d = cfg_q[i];
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) reg_rdata <= IOPG_RST8;
    else if (reg_rd) reg_rdata <= rdata_d;
    else reg_rdata <= IOPG_RST8;
  end

  a_dir_set_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr && reg_addr == IOPG_DRIVE_ENABLE_SET |=> (dir_q & $past(reg_wdata)) ==
      $past(reg_wdata))
    else $error("drive enable set lost");
  a_dir_toggle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr && reg_addr == IOPG_DRIVE_ENABLE_TOGGLE |=> dir_q == ($past(dir_q) ^
      $past(reg_wdata)))
    else $error("drive enable toggle wrong");
  a_out_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr && reg_addr == IOPG_DRIVE_VALUE_CLEAR |=> (out_q & $past(reg_wdata)) == 8'h00)
    else $error("drive value clear failed");
  a_in_toggle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr && ea == IOPG_IN |=> out_q == ($past(out_q) ^ $past(reg_wdata)))
    else $error("sampled level write did not toggle");
  a_oe_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    per_oe_ovr == 8'h00 |=> pad_oe == $past(dir_q))
    else $error("driver not following direction");
  a_pull_off_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 (pad_pull & pad_oe) == 8'h00)
    else $error("pull-up on driven pin");
  a_copy_cfg: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr && reg_addr == IOPG_COPY && reg_wdata[0] |=>
      cfg_q[0] == ($past(stage_in) & IOPG_CFG_MASK))
    else $error("copy strobe did not load pin 0");
  a_irq_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    flag_q != 8'h00 |=> pin_irq)
    else $error("request missing with flag set");
  a_slew_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr && reg_addr == IOPG_GCTRL && reg_wdata[0] |-> ##2 pad_slew_limit)
    else $error("slew limit not applied");

  // Clear strobe on the drive enable must drop every written bit
  a_dir_clr_bit: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    wr && reg_addr == IOPG_DRIVE_ENABLE_CLEAR |=> (dir_q & $past(reg_wdata)) == 8'h00)
    else $error("drive enable clear lost");
  // Set strobe on the drive value forces the written bits high
  a_out_set_bit: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    wr && reg_addr == IOPG_DRIVE_VALUE_SET |=>
      (out_q & $past(reg_wdata)) == $past(reg_wdata))
    else $error("drive value set lost");
  // Toggle strobe inverts exactly the written bits
  a_out_tgl_bit: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    wr && reg_addr == IOPG_DRIVE_VALUE_TOGGLE |=> out_q == ($past(out_q) ^
      $past(reg_wdata)))
    else $error("drive value toggle wrong");
  // Buffer enable follows the sense setting one clock later
  a_ibuf_follow: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    1'b1 |=> pad_ibuf_en == $past(pif.sense_on))
    else $error("input buffer enable wrong");
  // Events are gated off while the buffer is disabled
  a_event_gate: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    1'b1 |=> pin_event == ($past(pif.level) & $past(pif.sense_on)))
    else $error("event output not gated");
  // Peripherals see the polarity-corrected level, flip edges included
  a_level_out: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    1'b1 |=> pin_level == $past(pif.level))
    else $error("pin level not forwarded");
  // No new flag on pin 0 while its dead time runs
  a_dead_hold: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    dead_q[0] != 2'h0 && !flag_q[0] |=> !flag_q[0])
    else $error("flag set inside dead time");
  // Every new flag on pin 0 starts a full dead time
  a_dead_load: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    $rose(flag_q[0]) |-> dead_q[0] == IOPG_DEAD_CYC)
    else $error("dead time not started");
  // Request drops once every flag is cleared
  a_irq_clear: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    flag_q == 8'h00 |=> !pin_irq)
    else $error("request without flag");
  // Or strobe sets on pin 0 every bit that is one in the stage
  a_cfg_or_bit: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    wr && reg_addr == IOPG_ORSET && reg_wdata[0] |=>
      (cfg_q[0] & $past(stage_in) & IOPG_CFG_MASK) ==
      ($past(stage_in) & IOPG_CFG_MASK))
    else $error("or strobe missed a bit");
  // And-not strobe clears on pin 0 every bit that is one in the stage
  a_cfg_andnot: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    wr && reg_addr == IOPG_ANDCLR && reg_wdata[0] |=>
      (cfg_q[0] & $past(stage_in)) == 8'h00)
    else $error("and-not strobe left a bit");
  // Pin 5 configuration sits at its own offset
  a_cfg_addr: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    wr && reg_addr == IOPG_PINCFG + 6'h05 |=>
      cfg_q[5] == ($past(reg_wdata) & IOPG_CFG_MASK))
    else $error("pin configuration offset wrong");
  // A stage write reaches the shared storage as a one-cycle request
  a_stage_req: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    wr && reg_addr == IOPG_STAGE |=> stage_wr &&
      stage_wr_data == ($past(reg_wdata) & IOPG_CFG_MASK))
    else $error("stage write request missing");
  // Without a claim the driven level is the drive value in pin polarity
  a_drive_flip: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    per_out_ovr == 8'h00 |=> pad_out == ($past(out_q) ^ $past(flip)))
    else $error("drive level polarity wrong");
  // With the buffer off the sampled bit of pin 0 must hold
  a_sync_hold: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    !pif.sense_on[0] |=> $stable(pif.level[0]))
    else $error("sampled bit moved with buffer off");
endmodule

// >>> test/iopg_pad_model.sv
/*
  Far side of the I/O pin group: pin wires and the shared staged setting.
  Assumes one clock; a pin nobody drives floats to a moving pattern.
*/
`timescale 1ns/1ps
module iopg_pad_model
  import iopg_pkg::*;
(
  input wire logic ref_clk,             // Peripheral clock
  input wire logic rst_n,               // Sync reset, active low
  input wire logic [7:0] pad_out,       // Device drive levels
  input wire logic [7:0] pad_oe,        // Device drive enables
  input wire logic [7:0] pad_pull,      // Weak pull-ups
  input wire logic [7:0] ext_en,        // Outside source drives pin
  input wire logic [7:0] ext_lvl,       // Outside source level
  input wire logic stage_wr,            // Stage write request
  input wire logic [7:0] stage_wr_data, // Stage write data
  output logic [7:0] stage_in,          // Shared stage value
  output logic [7:0] pad_in             // Resolved pin levels
);
  logic [7:0] float_q = 8'h55;
  // Floating pins change every cycle so a stale level never matches
  always_ff @(posedge ref_clk) float_q <= ~float_q;
  // Device driver wins, then the outside source, then the pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_lvl[i];
      else if (pad_pull[i]) pad_in[i] = 1'b1;
      else pad_in[i] = float_q[i];
    end
  end
  // One storage seen by every group
  always_ff @(posedge ref_clk) begin
    if (!rst_n) stage_in <= IOPG_RST8;
    else if (stage_wr) stage_in <= stage_wr_data;
  end
endmodule

// >>> test/iopg_top_tb.sv
/*
  Self-checking bench of the I/O pin group against a register model.
  Assumes the pad model on the far side and a 200 MHz clock.
*/
`timescale 1ns/1ps
module iopg_top_tb;
  import iopg_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] per_oe_ovr = 8'h00, per_oe = 8'h00;
  logic [7:0] per_out_ovr = 8'h00, per_out = 8'h00;
  logic [7:0] ext_en = 8'h00, ext_lvl = 8'h00;
  logic [7:0] reg_rdata, stage_in, stage_wr_data, pad_in, pad_out, pad_oe;
  logic [7:0] pad_pull, pad_ibuf_en, pin_level, pin_event;
  logic stage_wr, pad_slew_limit, pin_irq;
  logic [7:0] m_dir, m_out, m_stage, rd_q, lvl, x;
  logic [7:0] m_cfg [8];
  logic [5:0] ops [11];
  int err_count = 0;
  int num_checks = 0;

  always #2.5 ref_clk = ~ref_clk;

  iopg_top iopg_top_inst (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .stage_in, .stage_wr_data, .stage_wr, .pad_in,
    .pad_out, .pad_oe, .pad_pull, .pad_ibuf_en, .pad_slew_limit,
    .per_oe_ovr, .per_oe, .per_out_ovr, .per_out, .pin_level, .pin_event,
    .pin_irq);
  iopg_pad_model iopg_pad_model_inst (.ref_clk, .rst_n, .pad_out, .pad_oe,
    .pad_pull, .ext_en, .ext_lvl, .stage_wr, .stage_wr_data, .stage_in,
    .pad_in);

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // Strobe then one idle cycle; the gap also keeps alias and regular
  // accesses apart
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic chk_rd(input logic [5:0] a, input logic [7:0] e,
                        input string nm);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
    chk8(nm, e, rd_q);
  endtask
  // Write through the port and update the model
  task automatic mw(input logic [5:0] a, input logic [7:0] d);
    wr(a, d);
    case (a)
      IOPG_DIR, IOPG_ALIAS: m_dir = d;
      IOPG_DRIVE_ENABLE_SET: m_dir |= d;
      IOPG_DRIVE_ENABLE_CLEAR: m_dir &= ~d;
      IOPG_DRIVE_ENABLE_TOGGLE: m_dir ^= d;
      IOPG_OUT, IOPG_ALIAS + 6'h01: m_out = d;
      IOPG_DRIVE_VALUE_SET: m_out |= d;
      IOPG_DRIVE_VALUE_CLEAR: m_out &= ~d;
      IOPG_DRIVE_VALUE_TOGGLE, IOPG_IN, IOPG_ALIAS + 6'h02: m_out ^= d;
      IOPG_STAGE: m_stage = d;
      IOPG_COPY: for (int i = 0; i < 8; i++) if (d[i]) m_cfg[i] = m_stage;
      IOPG_ORSET: for (int i = 0; i < 8; i++) if (d[i]) m_cfg[i] |= m_stage;
      IOPG_ANDCLR: for (int i = 0; i < 8; i++) if (d[i]) m_cfg[i] &= ~m_stage;
      default: if (a[5:3] == 3'h2) m_cfg[a[2:0]] = d & IOPG_CFG_MASK;
    endcase
  endtask
  // Pad outputs expected from model registers and peripheral claims
  task automatic chk_pads();
    logic [7:0] oe, fl, pu, ib;
    repeat (3) @(posedge ref_clk);
    #1;
    for (int i = 0; i < 8; i++) begin
      fl[i] = m_cfg[i][IOPG_FLIP_BIT];
      pu[i] = m_cfg[i][IOPG_PULL_BIT];
      ib[i] = m_cfg[i][2:0] != IOPG_SENSE_OFF;
    end
    oe = (per_oe_ovr & per_oe) | (~per_oe_ovr & m_dir);
    x = (per_out_ovr & per_out) | (~per_out_ovr & (m_out ^ fl));
    chk8("pad_oe", oe, pad_oe);
    chk8("pad_out", x, pad_out);
    chk8("pad_pull", pu & ~oe, pad_pull);
    chk8("pad_ibuf_en", ib, pad_ibuf_en);
  endtask

  initial begin
    #200000;
    err_count++;
    $display("unexpected run_time exp done got hang");
    end_sim();
  end

  initial begin
    void'($urandom(32'hF272));
    ops = '{IOPG_DIR, IOPG_DRIVE_ENABLE_SET, IOPG_DRIVE_ENABLE_CLEAR, IOPG_DRIVE_ENABLE_TOGGLE, IOPG_OUT,
      IOPG_DRIVE_VALUE_SET, IOPG_DRIVE_VALUE_CLEAR, IOPG_DRIVE_VALUE_TOGGLE, IOPG_IN, IOPG_ALIAS,
      IOPG_ALIAS + 6'h01};
    for (int i = 0; i < 8; i++) m_cfg[i] = 8'h00;
    m_dir = 8'h00;
    m_out = 8'h00;
    m_stage = 8'h00;
    repeat (5) @(posedge ref_clk);
    #1;
    chk8("reset oe", 8'h00, pad_oe);
    chk8("reset ibuf", 8'hFF, pad_ibuf_en);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    chk_rd(IOPG_DIR, 8'h00, "reset dir");
    chk_rd(IOPG_PINCFG + 6'h07, 8'h00, "reset cfg");
    chk_rd(6'h0F, 8'h00, "unmapped");
    // Random strobe traffic, zero bits included
    for (int k = 0; k < 60; k++) begin
      mw(ops[$urandom % 11], 8'($urandom));
      chk_rd(IOPG_DIR, m_dir, "dir");
      chk_rd(IOPG_ALIAS + 6'h01, m_out, "alias out");
      chk_pads();
    end
    // Peripheral claims on direction and value
    for (int k = 0; k < 8; k++) begin
      @(posedge ref_clk);
      per_oe_ovr <= 8'($urandom);
      per_oe <= 8'($urandom);
      per_out_ovr <= 8'($urandom);
      per_out <= 8'($urandom);
      chk_pads();
    end
    per_oe_ovr <= 8'h00;
    per_out_ovr <= 8'h00;
    // Input sampling in both directions
    mw(IOPG_DIR, 8'h00);
    lvl = 8'($urandom);
    ext_en <= 8'hFF;
    ext_lvl <= lvl;
    chk_pads();
    chk_rd(IOPG_IN, lvl, "in");
    chk8("pin_level", lvl, pin_level);
    chk8("pin_event", lvl, pin_event);
    mw(IOPG_DIR, 8'hFF);
    chk_pads();
    chk_rd(IOPG_IN, m_out, "in output");
    mw(IOPG_DIR, 8'h00);
    // Slew limit on and off
    for (int v = 1; v >= 0; v--) begin
      mw(IOPG_GCTRL, 8'(v));
      chk_pads();
      chk8("slew", 8'(v), {7'h00, pad_slew_limit});
    end
    // Polarity flip on pin 3 makes an edge on its internal level
    mw(IOPG_PINCFG + 6'h03, 8'h80);
    chk_pads();
    chk8("flip level", lvl ^ 8'h08, pin_level);
    chk_rd(IOPG_IN, lvl ^ 8'h08, "flip in");
    // Buffer off on pin 0 holds its sampled bit
    mw(IOPG_PINCFG, {5'h00, IOPG_SENSE_OFF});
    @(posedge ref_clk);
    ext_lvl <= ~lvl;
    chk_pads();
    chk_rd(IOPG_IN, {~lvl[7:1] ^ 7'h04, lvl[0]}, "in hold");
    chk8("event off", 8'h00, pin_event & 8'h01);
    // Rising edge on pin 1 raises its flag; writing one clears it
    mw(IOPG_PINCFG + 6'h01, 8'h02);
    ext_lvl <= ext_lvl & 8'hFD;
    chk_pads();
    ext_lvl <= ext_lvl | 8'h02;
    chk_pads();
    chk_rd(IOPG_FLAGS, 8'h02, "flags");
    chk8("irq set", 8'h01, {7'h00, pin_irq});
    mw(IOPG_ALIAS + 6'h03, 8'h02);
    chk_rd(IOPG_FLAGS, 8'h00, "flags clear");
    chk8("irq clear", 8'h00, {7'h00, pin_irq});
    // Staged multi-pin updates
    mw(IOPG_DIR, 8'($urandom));
    for (int k = 0; k < 20; k++) begin
      mw(IOPG_STAGE, 8'($urandom) & 8'h8D);
      chk_rd(IOPG_STAGE, m_stage, "stage");
      mw(IOPG_COPY + 6'($urandom % 3), 8'($urandom));
      for (int i = 0; i < 8; i++) begin
        chk_rd(IOPG_PINCFG + 6'(i), m_cfg[i], "pin cfg");
      end
      chk_pads();
    end
    end_sim();
  end
endmodule
